// *** rtl/serial_flash_pkg.sv ***
package serial_flash_pkg;
	localparam int INSTR_BITS = 8;
	localparam int DATA_BITS = 8;
	localparam int FIFO_DEPTH = 4;
	localparam int BIT_CNT_W = 3;
	localparam logic [BIT_CNT_W-1:0] BIT_CNT_RESET = 3'h0;
	localparam logic [BIT_CNT_W-1:0] BIT_CNT_LAST = 3'h7;
	localparam logic [DATA_BITS-1:0] SHIFT_RESET = 8'h00;
	localparam int LINK_PERIOD_NS = 48;
	localparam int CORE_PERIOD_NS = 4;

	typedef struct packed {
		logic select_n;
		logic shift_clock;
		logic instr_in;
	} pin_in_t;

	typedef struct packed {
		logic data_out;
		logic data_oe;
	} pin_out_t;

	typedef enum logic [1:0] {
		ST_WAIT_ARM = 2'b00,
		ST_IDLE = 2'b01,
		ST_ACTIVE = 2'b10
	} link_state_t;
endpackage

// *** rtl/byte_fifo.sv ***
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic flush,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [AW:0] cnt_q, cnt_d;
	logic push, pop;

	assign in_ready = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data = mem_q[rd_q];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		wr_d = wr_q;
		rd_d = rd_q;
		cnt_d = cnt_q;
		if (flush) begin
			wr_d = '0;
			rd_d = '0;
			cnt_d = '0;
		end else begin
			if (push) begin
				wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
			end
			cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
		end
	end

	always_ff @(posedge core_clk) begin
		if (push && !flush) begin
			mem_q[wr_q] <= in_data;
		end
	end
endmodule

// *** rtl/serial_flash_link.sv ***
//////////////////////////////////////////////////////////////////////
// Contract
// - The serial output changes only on falling shift clock edges while data goes out.
// - The serial input is sampled on every rising shift clock edge while selected, one bit per edge.
// - Bits on the serial input form instructions and program data, shifted in one by one.
// - With select high the device is deselected and its output is high impedance.
// - With select low the device is active, takes clock edges and drives returned data.
// - After power-up nothing starts before a falling select edge is seen; select held low through reset counts as one, since select_n resets high.
//////////////////////////////////////////////////////////////////////
module serial_flash_link
	import serial_flash_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// Pins from the master
	input wire pin_in_t pins_in,
	// Serial output pin
	output pin_out_t pins_out,
	// Received words to the memory core
	output logic [DATA_BITS-1:0] rx_data,
	output logic rx_valid,
	input wire logic rx_ready,
	// Words to return from the memory core
	input wire logic [DATA_BITS-1:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	// Status
	output logic selected,
	output logic rx_overflow
);
	//////////////////////////////////////////////////////////////////
	// Pin synchronisers
	pin_in_t meta_q, sync_q, prev_q;

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_q <= '{select_n: 1'b1, shift_clock: 1'b0, instr_in: 1'b0};
			sync_q <= '{select_n: 1'b1, shift_clock: 1'b0, instr_in: 1'b0};
			prev_q <= '{select_n: 1'b1, shift_clock: 1'b0, instr_in: 1'b0};
		end else begin
			meta_q <= pins_in;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	logic clk_rise, clk_fall, sel_fall, sel_rise, sel_low;
	assign clk_rise = sync_q.shift_clock && !prev_q.shift_clock;
	assign clk_fall = !sync_q.shift_clock && prev_q.shift_clock;
	assign sel_fall = !sync_q.select_n && prev_q.select_n;
	assign sel_rise = sync_q.select_n && !prev_q.select_n;
	assign sel_low = !sync_q.select_n;

	//////////////////////////////////////////////////////////////////
	// Frame state and input shifter
	link_state_t state_q, state_d;
	logic [BIT_CNT_W-1:0] in_cnt_q, in_cnt_d, out_cnt_q, out_cnt_d;
	logic [DATA_BITS-1:0] in_sh_q, in_sh_d, out_sh_q, out_sh_d;
	logic word_done, out_load, fifo_in_ready;
	logic out_bit_q, out_bit_d, out_oe_q, out_oe_d, ovf_q, ovf_d;
	logic out_live_q, out_live_d;
	logic selected_q, selected_d;
	logic [DATA_BITS-1:0] word_in;

	assign word_in = {in_sh_q[DATA_BITS-2:0], sync_q.instr_in};
	assign word_done = (state_q == ST_ACTIVE) && sel_low && clk_rise && (in_cnt_q == BIT_CNT_LAST);

	always_comb begin
		state_d = state_q;
		in_cnt_d = in_cnt_q;
		in_sh_d = in_sh_q;
		ovf_d = ovf_q;
		case (state_q)
			ST_WAIT_ARM, ST_IDLE: begin
				if (sel_fall) begin
					state_d = ST_ACTIVE;
					in_cnt_d = BIT_CNT_RESET;
					in_sh_d = SHIFT_RESET;
				end
			end
			ST_ACTIVE: begin
				if (sync_q.select_n) begin
					state_d = ST_IDLE;
					in_cnt_d = BIT_CNT_RESET;
					in_sh_d = SHIFT_RESET;
				end else if (clk_rise) begin
					in_sh_d = word_in;
					in_cnt_d = in_cnt_q + 1'b1;
					if (in_cnt_q == BIT_CNT_LAST && !fifo_in_ready) begin
						ovf_d = 1'b1;
					end
				end
			end
			default: state_d = ST_WAIT_ARM;
		endcase
		selected_d = (state_d == ST_ACTIVE);
	end

	//////////////////////////////////////////////////////////////////
	// Output shifter
	assign out_load = (state_q == ST_ACTIVE) && sel_low && clk_fall && (out_cnt_q == BIT_CNT_RESET);
	assign tx_ready = out_load;

	always_comb begin
		out_bit_d = out_bit_q;
		out_sh_d = out_sh_q;
		out_cnt_d = out_cnt_q;
		out_live_d = out_live_q;
		out_oe_d = out_oe_q;
		if (state_q != ST_ACTIVE || sync_q.select_n) begin
			out_oe_d = 1'b0;
			out_live_d = 1'b0;
			out_cnt_d = BIT_CNT_RESET;
		end else if (clk_fall) begin
			if (out_cnt_q == BIT_CNT_RESET) begin
				out_live_d = tx_valid;
				out_oe_d = tx_valid;
				if (tx_valid) begin
					out_bit_d = tx_data[DATA_BITS-1];
					out_sh_d = {tx_data[DATA_BITS-2:0], 1'b0};
					out_cnt_d = out_cnt_q + 1'b1;
				end
			end else if (out_live_q) begin
				out_bit_d = out_sh_q[DATA_BITS-1];
				out_sh_d = {out_sh_q[DATA_BITS-2:0], 1'b0};
				out_cnt_d = out_cnt_q + 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= ST_WAIT_ARM;
			selected_q <= 1'b0;
			in_cnt_q <= BIT_CNT_RESET;
			in_sh_q <= SHIFT_RESET;
			ovf_q <= 1'b0;
			out_bit_q <= 1'b0;
			out_sh_q <= SHIFT_RESET;
			out_cnt_q <= BIT_CNT_RESET;
			out_live_q <= 1'b0;
			out_oe_q <= 1'b0;
		end else begin
			state_q <= state_d;
			selected_q <= selected_d;
			in_cnt_q <= in_cnt_d;
			in_sh_q <= in_sh_d;
			ovf_q <= ovf_d;
			out_bit_q <= out_bit_d;
			out_sh_q <= out_sh_d;
			out_cnt_q <= out_cnt_d;
			out_live_q <= out_live_d;
			out_oe_q <= out_oe_d;
		end
	end

	assign pins_out = '{data_out: out_bit_q, data_oe: out_oe_q};
	assign selected = selected_q;
	assign rx_overflow = ovf_q;

	//////////////////////////////////////////////////////////////////
	// Receive buffer
	byte_fifo #(.WIDTH(DATA_BITS), .DEPTH(FIFO_DEPTH)) rx_fifo (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.flush(1'b0),
		.in_valid(word_done),
		.in_ready(fifo_in_ready),
		.in_data(word_in),
		.out_valid(rx_valid),
		.out_ready(rx_ready),
		.out_data(rx_data)
	);

	//////////////////////////////////////////////////////////////////
	// Checks
	sequence s_desel;
		sync_q.select_n;
	endsequence

	AST_HIZ_DESELECT: assert property (@(posedge core_clk) disable iff (!reset_n)
		s_desel |=> !pins_out.data_oe)
		else $error("Output driven while deselected");
	AST_OUT_ON_FALL: assert property (@(posedge core_clk) disable iff (!reset_n)
		$changed(pins_out.data_out) |-> $past(clk_fall))
		else $error("Output changed off a falling edge");
	AST_ARM_NEEDS_FALL: assert property (@(posedge core_clk) disable iff (!reset_n)
		(state_q != ST_ACTIVE) && !sel_fall |=> state_q != ST_ACTIVE)
		else $error("Armed without a select fall");
	AST_SAMPLE_RISE: assert property (@(posedge core_clk) disable iff (!reset_n)
		(state_q == ST_ACTIVE) && sel_low && clk_rise |=> in_sh_q[0] == $past(sync_q.instr_in))
		else $error("Input bit not taken on rising edge");
	AST_COUNT_STEP: assert property (@(posedge core_clk) disable iff (!reset_n)
		(state_q == ST_ACTIVE) && sel_low && clk_rise |=> in_cnt_q == $past(in_cnt_q) + 3'h1)
		else $error("Bit counter did not advance");
	AST_RISE_CLEARS: assert property (@(posedge core_clk) disable iff (!reset_n)
		(state_q == ST_ACTIVE) && sync_q.select_n |=> in_cnt_q == BIT_CNT_RESET && !selected)
		else $error("Partial word kept after select rise");
	AST_ACTIVE_DRIVE: assert property (@(posedge core_clk) disable iff (!reset_n)
		out_load && tx_valid |=> pins_out.data_oe && pins_out.data_out == $past(tx_data[DATA_BITS-1]))
		else $error("Returned data not driven");
	AST_WORD_PUSH: assert property (@(posedge core_clk) disable iff (!reset_n)
		word_done && fifo_in_ready |=> rx_valid)
		else $error("Completed word not buffered");
endmodule

// *** verif/master_model.sv ***
module master_model
	import serial_flash_pkg::*;
(
	// Clock and line
	input wire logic core_clk,
	input wire logic serial_line,
	// Pins to the device
	output pin_in_t pins
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] got;
	logic moved;
	logic seen;
	initial begin
		pins = 3'h4;
		got = 16'h0000;
		moved = 1'b0;
	end
	task automatic half(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic frame(input logic [15:0] bits, input int n, input logic armed);
		moved = 1'b0;
		pins.select_n = ~armed;
		half(6);
		for (int i = 15; i > 15 - n; i--) begin
			pins.instr_in = bits[i];
			half(6);
			seen = serial_line;
			pins.shift_clock = 1'b1;
			half(5);
			pins.instr_in = ~bits[i];
			half(1);
			moved = moved | (serial_line !== seen);
			got = {got[14:0], serial_line};
			pins.shift_clock = 1'b0;
		end
		half(6);
		pins.select_n = 1'b1;
		half(6);
	endtask
endmodule

// *** verif/test_serial_config_flash_pin_interface.sv ***
module test_serial_config_flash_pin_interface
	import serial_flash_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic rx_ready = 1'b0;
	logic tx_valid = 1'b0;
	logic [DATA_BITS-1:0] tx_data = 8'h00;
	logic [DATA_BITS-1:0] rx_data;
	logic rx_valid;
	logic tx_ready;
	logic selected;
	logic rx_overflow;
	pin_in_t pins;
	pin_out_t pout;
	wire logic line = pout.data_oe ? pout.data_out : 1'bz;
	int err_total = 0;
	int samples_checked = 0;
	always #(CORE_PERIOD_NS / 2) core_clk = ~core_clk;
	// Words taken on the return path
	logic [7:0] tx_taken = 8'h00;
	always @(posedge core_clk) begin
		if (tx_ready && tx_valid) begin
			tx_taken <= tx_taken + 8'h01;
		end
	end
	master_model m (.core_clk(core_clk), .serial_line(line), .pins(pins));
	serial_flash_link dut (.core_clk(core_clk), .reset_n(reset_n), .pins_in(pins),
		.pins_out(pout), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.selected(selected), .rx_overflow(rx_overflow));
	//////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic check_flag(input string what, input logic exp, input logic seen);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %b seen %b", what, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("checked %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic pop(input logic [7:0] exp);
		int i;
		for (i = 0; i < 64 && rx_valid !== 1'b1; i++) @(negedge core_clk);
		if (i == 64) begin
			check_flag("rx_valid wait", 1'b1, 1'b0);
			final_report();
		end
		check("rx_data", exp, rx_data);
		rx_ready = 1'b1;
		@(negedge core_clk);
		rx_ready = 1'b0;
		@(negedge core_clk);
	endtask
	//////////////////////////////////////////////////////////////////////
	task automatic t_idle();
		m.frame(16'hffff, 8, 1'b0);
		check_flag("rx_valid", 1'b0, rx_valid);
		check_flag("selected", 1'b0, selected);
		check_flag("data_oe", 1'b0, pout.data_oe);
		check_flag("rx_overflow", 1'b0, rx_overflow);
		$display("test idle done");
	endtask
	task automatic t_write();
		fork
			m.frame(16'ha500, 8, 1'b1);
			begin
				repeat (20) @(negedge core_clk);
				check_flag("selected", 1'b1, selected);
			end
		join
		pop(8'ha5);
		$display("test write done");
	endtask
	task automatic t_partial();
		m.frame(16'hf800, 5, 1'b1);
		m.frame(16'h3c00, 8, 1'b1);
		pop(8'h3c);
		check_flag("rx_valid", 1'b0, rx_valid);
		$display("test partial done");
	endtask
	task automatic t_read();
		logic [7:0] base;
		base = tx_taken;
		tx_data = 8'hc3;
		tx_valid = 1'b1;
		rx_ready = 1'b1;
		m.frame(16'h0000, 16, 1'b1);
		tx_valid = 1'b0;
		rx_ready = 1'b0;
		check("read byte", 8'hc3, m.got[14:7]);
		check_flag("moved on rise", 1'b0, m.moved);
		check("tx words taken", 8'h02, tx_taken - base);
		check_flag("data_oe", 1'b0, pout.data_oe);
		$display("test read done");
	endtask
	task automatic t_fifo();
		m.frame(16'h1122, 16, 1'b1);
		m.frame(16'h3344, 16, 1'b1);
		m.frame(16'h5500, 8, 1'b1);
		check_flag("rx_overflow", 1'b1, rx_overflow);
		pop(8'h11);
		pop(8'h22);
		pop(8'h33);
		pop(8'h44);
		check_flag("rx_valid", 1'b0, rx_valid);
		$display("test fifo done");
	endtask
	initial begin
		repeat (2) @(negedge core_clk);
		reset_n = 1'b1;
		t_idle();
		t_write();
		t_partial();
		t_read();
		t_fifo();
		final_report();
	end
endmodule
